// ===== logic/dmatc_consts.svh
// Summary of operation
// - count complete clears run bit by itself
// - enable write taken only while run is zero
// - each transfer stalls the cpu two clocks
// - hold bit keeps triggers pending until cleared
// - one remembered trigger per channel at most
// - hold takes effect two clocks after write
// - run cleared by software stops within two clocks
// - other channel waits for ongoing transfer
// - channel 0 wins same cycle requests
// - dma transfer goes before interrupt servicing
// - trigger to start between 3 and 10 clocks
// - deferring instruction lengthens the maximum delay
// - halt keeps running, stop mode freezes channels, sequencer, counts and run bits and drops the interrupt hold
// - requests deferred after calls, break, flag writes
// - 4-bit select picks trigger, 1100b is conversion end
// - abort gives no done interrupt, keeps count
// - count reaching zero raises done and ends
// - waits for triggers only while run, set by 81h
`ifndef DMATC_CONSTS_SVH
`define DMATC_CONSTS_SVH
// register byte offsets
`define DMATC_OFS_CTL0      12'h000
`define DMATC_OFS_MODE0     12'h004
`define DMATC_OFS_CNT0      12'h008
`define DMATC_OFS_CTL1      12'h010
`define DMATC_OFS_MODE1     12'h014
`define DMATC_OFS_CNT1      12'h018
// field positions
`define DMATC_CTL_RUN       0
`define DMATC_CTL_EN        7
`define DMATC_MODE_SWT      7
`define DMATC_MODE_HOLD     4
`define DMATC_SEL_HI        3
`define DMATC_SEL_LO        0
`define DMATC_CNT_W         10
// select codes
`define DMATC_SRC_OFF       4'h0
`define DMATC_SRC_ADC       4'hC
// reset values
`define DMATC_RST_WORD      32'h0000_0000
`define DMATC_RST_CNT       10'h000
// timing, in cpu clocks
`define DMATC_XFER_CLKS     2
`define DMATC_HOLD_CLKS     2
`define DMATC_RESP_MIN      3
`define DMATC_RESP_MAX      10
`define DMATC_AGE_GO        (`DMATC_RESP_MIN - 2)
`endif

// ===== logic/dmatc_pkg.sv
`include "dmatc_consts.svh"
package dmatc_pkg;
    // transfer sequencer states
    typedef enum logic [1:0] {
        xf_idle = 2'b00,
        xf_move = 2'b01,
        xf_last = 2'b10
    } dmatc_xstate_t;
    // remaining transfer count
    typedef logic [`DMATC_CNT_W-1:0] dmatc_cnt_t;
endpackage : dmatc_pkg

// ===== logic/dmatc_xfer_if.sv
`timescale 1ns/10ps
// grant and transfer handshake between arbiter and sequencer
interface dmatc_xfer_if;
    logic act;    // high unless in stop standby
    logic go;     // one-cycle grant
    logic go_ch;  // granted channel
    logic busy;   // transfer underway, cpu stalled
    logic fin;    // last cycle of a transfer
    logic ch;     // channel being moved
    modport ctl (output act, output go, output go_ch,
                 input busy, input fin, input ch);
    modport seq (input act, input go, input go_ch,
                 output busy, output fin, output ch);
endinterface : dmatc_xfer_if

// ===== logic/dmatc_chan.sv
`timescale 1ns/10ps
`include "dmatc_consts.svh"
// per-channel trigger latch, hold delay and response ageing
module dmatc_chan import dmatc_pkg::*; (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic act,
    input  wire logic run,
    input  wire logic hold_bit,
    input  wire logic trig,
    input  wire logic served,
    output logic      req,
    output logic      pend,
    output logic      hold_eff
);
    logic [1:0] hold_d_reg;  // hold bit delay line
    logic       pend_reg;    // single remembered trigger
    logic [1:0] age_reg;     // clocks since trigger

    // hold lags the write so a trigger in flight still goes
    always_ff @(posedge clock) begin
        if (rst) begin
            hold_d_reg <= 2'h0;
        end else if (act) begin
            hold_d_reg <= {hold_d_reg[0], hold_bit};
        end
    end
    assign hold_eff = hold_d_reg[`DMATC_HOLD_CLKS-1];

    // set wins over the clear; repeats fold into one flag
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_reg <= 1'b0;
        end else if (act) begin
            if (trig && run) begin
                pend_reg <= 1'b1;
            end else if (served || !run) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // age gives the minimum response delay
    always_ff @(posedge clock) begin
        if (rst) begin
            age_reg <= 2'h0;
        end else if (act) begin
            if (trig && run && (!pend_reg || served)) begin
                age_reg <= 2'h0;
            end else if (pend_reg && age_reg != 2'h3) begin
                age_reg <= age_reg + 2'h1;
            end
        end
    end

    assign pend = pend_reg;
    // released pending trigger simply reappears as a request
    assign req  = pend_reg && run && !hold_eff
                  && (age_reg >= 2'(`DMATC_AGE_GO));

    property p_hold_lag;
        @(posedge clock) disable iff (rst || !act)
        $rose(hold_bit) |-> !hold_eff ##2 hold_eff;
    endproperty
    a_hold_lag: assert property (p_hold_lag)
        else $error("hold did not take effect after two clocks");
    property p_hold_blocks;
        @(posedge clock) disable iff (rst)
        hold_eff |-> !req;
    endproperty
    a_hold_blocks: assert property (p_hold_blocks)
        else $error("request raised while channel held");
endmodule : dmatc_chan

// ===== logic/dmatc_xfer.sv
`timescale 1ns/10ps
`include "dmatc_consts.svh"
// two-clock transfer sequencer that stalls the cpu
module dmatc_xfer import dmatc_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    dmatc_xfer_if.seq x
);
    dmatc_xstate_t state_reg;  // sequencer state
    logic          ch_reg;     // channel being moved
    logic          stall_reg;  // cpu stall, both clocks

    // idle -> move -> last; frozen in stop standby
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= xf_idle;
            ch_reg    <= 1'b0;
            stall_reg <= 1'b0;
        end else if (x.act) begin
            case (state_reg)
                xf_idle: begin
                    if (x.go) begin
                        state_reg <= xf_move;
                        ch_reg    <= x.go_ch;
                        stall_reg <= 1'b1;
                    end
                end
                xf_move: begin
                    state_reg <= xf_last;
                end
                default: begin
                    state_reg <= xf_idle;
                    stall_reg <= 1'b0;
                end
            endcase
        end
    end
    assign x.busy = stall_reg;
    assign x.fin  = (state_reg == xf_last);
    assign x.ch   = ch_reg;

    property p_stall_two;
        @(posedge clock) disable iff (rst || !x.act)
        $rose(x.busy) |=> x.busy ##1 !x.busy;
    endproperty
    a_stall_two: assert property (p_stall_two)
        else $error("cpu stall not exactly two clocks");
endmodule : dmatc_xfer

// ===== logic/dmatc_top.sv
`timescale 1ns/10ps
`include "dmatc_consts.svh"
// two-channel dma trigger, hold, arbitration and stop control
module dmatc_top import dmatc_pkg::*; (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] periph_irq,
    input  wire logic        cpu_irq_req,
    input  wire logic        defer_instr,
    input  wire logic        stop_mode,
    output logic             cpu_stall,
    output logic      [1:0]  dma_go,
    output logic      [1:0]  transfer_done_irq,
    output logic             irq_hold
);
    dmatc_xfer_if x ();

    // software visible state
    logic [1:0] channel_enable_bit;    // enable per channel
    logic [1:0] channel_run_bit;       // run per channel
    logic [1:0] channel_hold_bit;      // hold per channel
    logic [1:0] stop_req_reg;          // abort waiting for transfer
    logic [3:0] trigger_source_select [2];
    dmatc_cnt_t remaining_count_reg [2];
    logic [1:0] software_trigger_bit;  // one-cycle trigger pulse

    // bus answer, go pulse, done and interrupt hold flops
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [1:0]  dma_go_reg;
    logic [1:0]  done_reg;
    logic        irq_hold_reg;

    // decode and arbitration terms
    logic        act;          // clock gate for stop standby
    logic        wr;           // write takes effect this edge
    logic [1:0]  wr_ctl;       // run_enable_control_reg write
    logic [1:0]  wr_mode;      // channel_mode_reg write
    logic [1:0]  wr_cnt;       // remaining_count_reg write
    logic [31:0] rd_word;      // read mux
    logic        rd_miss;      // unmapped address
    logic [1:0]  trig;         // raw trigger per channel
    logic [1:0]  req;          // aged, unheld requests
    logic [1:0]  pend;         // remembered triggers
    logic [1:0]  hold_eff;     // delayed hold
    logic [1:0]  elig;         // requests allowed into arbitration
    logic        can_go;       // arbiter free this cycle
    logic [1:0]  grant;        // one-hot grant
    dmatc_cnt_t  cnt_dec;      // count after the finishing transfer

    // halt standby needs nothing: only stop freezes the channels, sequencer, counts and run bits
    assign act = !stop_mode;

    // access completes in the first access cycle
    assign wr = psel && penable && pwrite && pready_reg;

    // write strobes by address
    always_comb begin
        wr_ctl  = 2'b00;
        wr_mode = 2'b00;
        wr_cnt  = 2'b00;
        if (!wr) begin
            wr_ctl = 2'b00;
        end else if (paddr == `DMATC_OFS_CTL0) begin
            wr_ctl[0] = 1'b1;
        end else if (paddr == `DMATC_OFS_CTL1) begin
            wr_ctl[1] = 1'b1;
        end else if (paddr == `DMATC_OFS_MODE0) begin
            wr_mode[0] = 1'b1;
        end else if (paddr == `DMATC_OFS_MODE1) begin
            wr_mode[1] = 1'b1;
        end else if (paddr == `DMATC_OFS_CNT0) begin
            wr_cnt[0] = 1'b1;
        end else if (paddr == `DMATC_OFS_CNT1) begin
            wr_cnt[1] = 1'b1;
        end
    end

    // read mux; the trigger bit always reads back zero
    always_comb begin
        rd_word = `DMATC_RST_WORD;
        rd_miss = 1'b0;
        if (paddr == `DMATC_OFS_CTL0) begin
            rd_word[`DMATC_CTL_EN]  = channel_enable_bit[0];
            rd_word[`DMATC_CTL_RUN] = channel_run_bit[0];
        end else if (paddr == `DMATC_OFS_CTL1) begin
            rd_word[`DMATC_CTL_EN]  = channel_enable_bit[1];
            rd_word[`DMATC_CTL_RUN] = channel_run_bit[1];
        end else if (paddr == `DMATC_OFS_MODE0) begin
            rd_word[`DMATC_MODE_HOLD] = channel_hold_bit[0];
            rd_word[`DMATC_SEL_HI:`DMATC_SEL_LO] =
                trigger_source_select[0];
        end else if (paddr == `DMATC_OFS_MODE1) begin
            rd_word[`DMATC_MODE_HOLD] = channel_hold_bit[1];
            rd_word[`DMATC_SEL_HI:`DMATC_SEL_LO] =
                trigger_source_select[1];
        end else if (paddr == `DMATC_OFS_CNT0) begin
            rd_word[`DMATC_CNT_W-1:0] = remaining_count_reg[0];
        end else if (paddr == `DMATC_OFS_CNT1) begin
            rd_word[`DMATC_CNT_W-1:0] = remaining_count_reg[1];
        end else begin
            rd_miss = 1'b1;
        end
    end

    // apb answer: data captured in setup, ready for one cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_reg  <= `DMATC_RST_WORD;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable;
            if (psel && !penable) begin
                prdata_reg  <= pwrite ? `DMATC_RST_WORD : rd_word;
                pslverr_reg <= rd_miss;
            end
        end
    end

    // mode registers; the trigger bit only pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            channel_hold_bit         <= 2'b00;
            software_trigger_bit     <= 2'b00;
            trigger_source_select[0] <= `DMATC_SRC_OFF;
            trigger_source_select[1] <= `DMATC_SRC_OFF;
        end else begin
            for (int n = 0; n < 2; n++) begin
                software_trigger_bit[n] <= wr_mode[n]
                    && pwdata[`DMATC_MODE_SWT];
                if (wr_mode[n]) begin
                    channel_hold_bit[n] <= pwdata[`DMATC_MODE_HOLD];
                    trigger_source_select[n] <=
                        pwdata[`DMATC_SEL_HI:`DMATC_SEL_LO];
                end
            end
        end
    end

    // select code 0 turns interrupt triggering off
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            trig[n] = software_trigger_bit[n]
                || (trigger_source_select[n] != `DMATC_SRC_OFF
                    && periph_irq[trigger_source_select[n]]);
        end
    end

    // per-channel trigger latch and hold
    for (genvar g = 0; g < 2; g++) begin : g_chan
        dmatc_chan u_chan (
            .clock    (clock),
            .rst      (rst),
            .act      (act),
            .run      (channel_run_bit[g]),
            .hold_bit (channel_hold_bit[g]),
            .trig     (trig[g]),
            .served   (grant[g]),
            .req      (req[g]),
            .pend     (pend[g]),
            .hold_eff (hold_eff[g])
        );
    end

    // no grant while busy, after a deferring instruction or stopped
    always_comb begin
        // a run-clearing write landing now must not meet a fresh grant
        elig   = req & channel_enable_bit & ~stop_req_reg
                 & ~(wr_ctl & {2{!pwdata[`DMATC_CTL_RUN]}});
        can_go = act && !x.busy && !defer_instr;
        grant[0] = can_go && elig[0];
        grant[1] = can_go && elig[1] && !elig[0];
    end
    assign x.act   = act;
    assign x.go    = |grant;
    assign x.go_ch = grant[1];

    dmatc_xfer u_xfer (
        .clock (clock),
        .rst   (rst),
        .x     (x)
    );

    assign cnt_dec = remaining_count_reg[x.ch] - 10'h001;

    // counts are only writable while the channel is stopped
    always_ff @(posedge clock) begin
        if (rst) begin
            remaining_count_reg[0] <= `DMATC_RST_CNT;
            remaining_count_reg[1] <= `DMATC_RST_CNT;
        end else if (act) begin
            for (int n = 0; n < 2; n++) begin
                if (x.fin && x.ch == n[0]) begin
                    remaining_count_reg[n] <= cnt_dec;
                end else if (wr_cnt[n] && !channel_run_bit[n]) begin
                    remaining_count_reg[n] <=
                        pwdata[`DMATC_CNT_W-1:0];
                end
            end
        end
    end

    // run, enable and abort handshake per channel
    always_ff @(posedge clock) begin
        if (rst) begin
            channel_enable_bit <= 2'b00;
            channel_run_bit    <= 2'b00;
            stop_req_reg       <= 2'b00;
            done_reg           <= 2'b00;
        end else begin
            done_reg <= 2'b00;
            for (int n = 0; n < 2; n++) begin
                if (!act) begin
                    // frozen; software writes are dropped, a pending abort is kept
                    stop_req_reg[n] <= stop_req_reg[n];
                end else if (x.fin && x.ch == n[0]
                             && cnt_dec == `DMATC_RST_CNT) begin
                    channel_run_bit[n] <= 1'b0;
                    stop_req_reg[n]    <= 1'b0;
                    done_reg[n]        <= 1'b1;
                end else if (x.fin && x.ch == n[0]
                             && stop_req_reg[n]) begin
                    // abort lands once the moving transfer ends
                    channel_run_bit[n] <= 1'b0;
                    stop_req_reg[n]    <= 1'b0;
                end else if (wr_ctl[n]) begin
                    if (!channel_run_bit[n]) begin
                        channel_enable_bit[n] <=
                            pwdata[`DMATC_CTL_EN];
                        channel_run_bit[n] <= pwdata[`DMATC_CTL_RUN]
                            && pwdata[`DMATC_CTL_EN];
                    end else if (!pwdata[`DMATC_CTL_RUN]) begin
                        // in the last stall cycle the transfer ends now
                        if (x.busy && x.ch == n[0] && !x.fin) begin
                            stop_req_reg[n] <= 1'b1;
                        end else begin
                            channel_run_bit[n] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // go pulses and interrupt hold for the cpu
    always_ff @(posedge clock) begin
        if (rst) begin
            dma_go_reg   <= 2'b00;
            irq_hold_reg <= 1'b0;
        end else begin
            dma_go_reg   <= grant;
            // keeps interrupt acknowledge behind dma work
            irq_hold_reg <= act && ((|elig) || x.go
                                    || (x.busy && !x.fin));
        end
    end

    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign cpu_stall         = x.busy;
    assign dma_go            = dma_go_reg;
    assign transfer_done_irq = done_reg;
    assign irq_hold          = irq_hold_reg;

    // helper: clocks a channel 0 request has been waiting
    logic [4:0] wait0_cnt;
    always_ff @(posedge clock) begin
        if (rst || !pend[0] || hold_eff[0] || !act || defer_instr
            || grant[0] || !channel_run_bit[0]) begin
            wait0_cnt <= 5'h00;
        end else if (wait0_cnt != 5'h1F) begin
            wait0_cnt <= wait0_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_done_clear;
        (act && x.fin && !x.ch && remaining_count_reg[0] == 10'h001)
        |=> (!channel_run_bit[0] && transfer_done_irq[0]);
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("last transfer did not clear run and flag done");
    property p_en_locked;
        (act && wr_ctl[0] && channel_run_bit[0])
        |=> channel_enable_bit[0] == $past(channel_enable_bit[0]);
    endproperty
    a_en_locked: assert property (p_en_locked)
        else $error("enable changed while run was set");
    property p_stop_two;
        (wr_ctl[0] && !pwdata[`DMATC_CTL_RUN] && channel_run_bit[0]
         && act) ##1 (act [*2]) |-> !channel_run_bit[0];
    endproperty
    a_stop_two: assert property (p_stop_two)
        else $error("run bit still set two clocks after clear");
    property p_no_abort_irq;
        $fell(channel_run_bit[0]) && remaining_count_reg[0] != 10'h000
        |-> !transfer_done_irq[0];
    endproperty
    a_no_abort_irq: assert property (p_no_abort_irq)
        else $error("done flagged on a forced stop");
    property p_one_at_time;
        x.busy |-> !x.go;
    endproperty
    a_one_at_time: assert property (p_one_at_time)
        else $error("grant issued during a transfer");
    property p_ch0_first;
        (can_go && elig[0] && elig[1]) |-> grant == 2'b01
            ##1 (x.busy && !x.ch);
    endproperty
    a_ch0_first: assert property (p_ch0_first)
        else $error("channel 1 served ahead of channel 0");
    property p_irq_after;
        x.go |=> (irq_hold && cpu_stall) ##1 irq_hold;
    endproperty
    a_irq_after: assert property (p_irq_after)
        else $error("interrupt not held behind dma transfer");
    property p_resp_min;
        grant[0] |-> $past(pend[0]);
    endproperty
    a_resp_min: assert property (p_resp_min)
        else $error("channel 0 started under three clocks");
    property p_resp_max;
        wait0_cnt <= 5'(`DMATC_RESP_MAX);
    endproperty
    a_resp_max: assert property (p_resp_max)
        else $error("channel 0 waited over ten clocks");
    property p_frozen;
        (stop_mode || defer_instr) |-> !x.go;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("grant during stop standby or deferral");

    c_both_req: cover property (elig == 2'b11);
    c_done: cover property (transfer_done_irq[0]);
    c_abort: cover property ($fell(channel_run_bit[1]) && !done_reg[1]);
    c_release: cover property ($fell(hold_eff[0]) && pend[0]);
endmodule : dmatc_top

// ===== test/dmatc_periph_model.sv
`timescale 1ns/10ps
// peripheral and cpu side: one interrupt pulse per fire request
module dmatc_periph_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        fire,
    input  wire logic [3:0]  code,
    output logic      [15:0] periph_irq,
    output logic             cpu_irq_req
);
    // pulse lasts one cycle, like a real interrupt flag edge
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_irq  <= 16'h0000;
            cpu_irq_req <= 1'b0;
        end else begin
            // cpu asks for service in the same cycle to contend with dma
            periph_irq  <= fire ? (16'h0001 << code) : 16'h0000;
            cpu_irq_req <= fire;
        end
    end
endmodule : dmatc_periph_model

// ===== test/dmatc_test.sv
`timescale 1ns/10ps
`include "dmatc_consts.svh"
// register-level tests of trigger, hold, priority and abort
module dmatc_test import dmatc_pkg::*; ;
    logic        clock = 1'b0;          // 100 mhz
    logic        rst = 1'b1;            // sync, active high
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        fire = 1'b0;           // asks the model for a pulse
    logic        stop = 1'b0;           // stop standby request
    logic        defer = 1'b0;          // deferring instruction running
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;                    // last read data
    logic [3:0]  code = 4'h0;           // which irq line to pulse
    logic [15:0] periph_irq;
    logic        pready, pslverr, cpu_irq_req, cpu_stall, irq_hold;
    logic [1:0]  dma_go, transfer_done_irq;
    logic [11:0] base [2] = '{`DMATC_OFS_CTL0, `DMATC_OFS_CTL1};
    int          mismatches = 0, cmp_count = 0;
    int          go_cnt = 0, done_cnt = 0, lat;

    dmatc_top i_dmatc_top (.clock(clock), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_irq(periph_irq), .cpu_irq_req(cpu_irq_req),
        .defer_instr(defer), .stop_mode(stop), .cpu_stall(cpu_stall),
        .dma_go(dma_go), .transfer_done_irq(transfer_done_irq),
        .irq_hold(irq_hold));
    dmatc_periph_model i_dmatc_periph_model (.clock(clock), .rst(rst),
        .fire(fire), .code(code), .periph_irq(periph_irq),
        .cpu_irq_req(cpu_irq_req));

    // clock
    always #5 clock = ~clock;
    // tallies of grants and done pulses, so extra ones show up
    always @(posedge clock) begin
        if (|dma_go) go_cnt++;
        if (|transfer_done_irq) done_cnt++;
    end

    task report_and_stop;
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // one apb transfer; held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk

    task trig(input logic [3:0] c);
        @(posedge clock);
        fire <= 1'b1; code <= c;
        @(posedge clock);
        fire <= 1'b0;
    endtask : trig

    // waits for a grant, then follows the two stall cycles
    task xfer(input logic [1:0] g, input logic [1:0] dn, input bit tl);
        lat = 0;
        do begin @(posedge clock); #1; lat++; end
        while (dma_go === 2'b00 && lat < 40);
        chk(dma_go, g);
        chk(irq_hold, 1'b1);
        if (tl) chk({lat >= 3, lat <= 10}, 2'b11);
        chk(cpu_stall, 1'b1);
        @(posedge clock); #1;
        chk({dma_go, cpu_stall}, 3'b001);
        @(posedge clock); #1;
        chk({transfer_done_irq, cpu_stall}, {dn, 1'b0});
    endtask : xfer

    // watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (6000) @(posedge clock);
        mismatches++;
        report_and_stop;
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rdchk(`DMATC_OFS_MODE0, `DMATC_RST_WORD);
        rdchk(`DMATC_OFS_CNT1, `DMATC_RST_WORD);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({31'h0, pslverr}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, base[c], 32'h0000_0080);
            apb(1'b1, base[c] + `DMATC_OFS_CNT0, 32'h0000_0002);
            apb(1'b1, base[c] + `DMATC_OFS_MODE0, {28'h0, `DMATC_SRC_ADC});
            apb(1'b1, base[c], 32'h0000_0081);
        end
        trig(4'h3);
        repeat (15) @(posedge clock);
        chk(go_cnt, 0);
        trig(`DMATC_SRC_ADC);
        xfer(2'b01, 2'b00, 1'b1);
        xfer(2'b10, 2'b00, 1'b0);
        rdchk(`DMATC_OFS_CNT1, 32'h0000_0001);
        apb(1'b1, `DMATC_OFS_CTL0, 32'h0000_0001);
        rdchk(`DMATC_OFS_CTL0, 32'h0000_0081);
        repeat (12) @(posedge clock);
        trig(`DMATC_SRC_ADC);
        xfer(2'b01, 2'b01, 1'b1);
        xfer(2'b10, 2'b10, 1'b0);
        rdchk(`DMATC_OFS_CTL0, 32'h0000_0080);
        rdchk(`DMATC_OFS_CTL1, 32'h0000_0080);
        // abort an idle running channel
        apb(1'b1, `DMATC_OFS_CNT0, 32'h0000_0003);
        apb(1'b1, `DMATC_OFS_CTL0, 32'h0000_0081);
        apb(1'b1, `DMATC_OFS_CTL0, 32'h0000_0080);
        rdchk(`DMATC_OFS_CTL0, 32'h0000_0080);
        rdchk(`DMATC_OFS_CNT0, 32'h0000_0003);
        apb(1'b1, `DMATC_OFS_CTL0, 32'h0000_0000);
        rdchk(`DMATC_OFS_CTL0, 32'h0000_0000);
        // held channel folds two software triggers into one
        apb(1'b1, `DMATC_OFS_CNT1, 32'h0000_0003);
        apb(1'b1, `DMATC_OFS_CTL1, 32'h0000_0081);
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0010);
        repeat (3) @(posedge clock);
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0090);
        repeat (12) @(posedge clock);
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0090);
        repeat (20) @(posedge clock);
        chk(go_cnt, 4);
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0000);
        xfer(2'b10, 2'b00, 1'b0);
        repeat (20) @(posedge clock);
        chk(go_cnt, 5);
        rdchk(`DMATC_OFS_CNT1, 32'h0000_0002);
        chk(done_cnt, 2);
        // stop standby drops a trigger, a deferral only delays one
        stop <= 1'b1;
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0080);
        repeat (15) @(posedge clock);
        stop <= 1'b0;
        defer <= 1'b1;
        chk(go_cnt, 5);
        apb(1'b1, `DMATC_OFS_MODE1, 32'h0000_0080);
        repeat (15) @(posedge clock);
        chk(go_cnt, 5);
        defer <= 1'b0;
        xfer(2'b10, 2'b00, 1'b0);
        rdchk(`DMATC_OFS_CNT1, 32'h0000_0001);
        // dual abort: hold both, stop both, release, then disable
        apb(1'b1, `DMATC_OFS_CTL0, 32'h0000_0081);
        for (int c = 0; c < 2; c++)
            apb(1'b1, base[c] + `DMATC_OFS_MODE0, 32'h0000_0010);
        for (int c = 0; c < 2; c++)
            apb(1'b1, base[c], 32'h0000_0080);
        for (int c = 0; c < 2; c++)
            apb(1'b1, base[c] + `DMATC_OFS_MODE0, 32'h0000_0000);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, base[c], 32'h0000_0000);
            rdchk(base[c], 32'h0000_0000);
        end
        report_and_stop;
    end
endmodule : dmatc_test
